// [cpu_bus_ctrl.sv]
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
module cpu_bus_ctrl (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // processor pins, asynchronous
    input wire logic i_cpu_reset,
    input wire logic i_ready,
    input wire logic i_nmi,
    input wire logic i_maskable_request,
    input wire logic i_bus_mode_strap,
    input wire logic i_hold_request,
    input wire logic [7:0] i_low_addr_data,
    // bus outputs
    output logic [7:0] o_low_addr_data,
    output logic o_low_addr_data_oe,
    output logic [7:0] o_mid_address_lines,
    output logic [3:0] o_top_address_status_lines,
    output logic o_ale,
    output logic [2:0] o_cycle_type_n,
    output logic o_request_acknowledge_strobe_n,
    output logic o_lock_n,
    output logic o_hold_ack
);
    import cpu_bus_pkg::*;

    logic [13:0] pins_s;
    logic ready_s, nmi_s, mreq_s, rst_pin_s, strap_s, hold_s;
    logic [7:0] ad_s;
    phase_type phase_reg, phase_next;
    ack_type ack_reg;
    logic [2:0] code_reg;
    logic [1:0] seg_reg;
    logic [19:0] addr_reg;
    logic [7:0] wdata_reg, rdata_reg, vtype_reg;
    logic [19:0] sw_addr_reg;
    logic [15:0] ioptr_reg;
    logic [2:0] sw_code_reg;
    logic [1:0] sw_seg_reg;
    logic sw_direct_reg, sw_pend_reg, boot_pend_reg;
    logic ie_reg, saved_ie_reg, nmi_pend_reg, nmi_prev_reg, hold_reg;
    logic [2:0] post_cnt_reg;
    logic rst_prev_reg;
    logic wr_en, start, start_ack, start_boot, start_sw, boundary;
    logic take_nmi, take_maskable_request, cyc_done, is_io, sw_ok;
    logic [19:0] sw_io_addr;
    logic [19:0] sw_next_addr;

    // every pin passes two flops before use
    pin_sync #(.WIDTH(14)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_async({i_cpu_reset, i_ready, i_nmi, i_maskable_request,
                  i_bus_mode_strap, i_hold_request, i_low_addr_data}),
        .o_sync(pins_s)
    );
    assign {rst_pin_s, ready_s, nmi_s, mreq_s, strap_s, hold_s} =
        pins_s[13:8];
    assign ad_s = pins_s[7:0];

    // apb decode; zero-wait, writes land at the access phase
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign o_pready = 1'b1;
    assign boundary = wr_en && (i_paddr == OFS_CTRL)
        && i_pwdata[CTRL_BOUNDARY_BIT];
    assign sw_ok = (i_pwdata[2:0] == CYC_IO_READ)
        || (i_pwdata[2:0] == CYC_IO_WRITE)
        || (i_pwdata[2:0] == CYC_FETCH)
        || (i_pwdata[2:0] == CYC_MEM_READ)
        || (i_pwdata[2:0] == CYC_MEM_WRITE);

    // interrupt decisions at an instruction boundary
    assign take_nmi = boundary && nmi_pend_reg && ack_reg == ACK_NONE;
    assign take_maskable_request = boundary && !nmi_pend_reg && mreq_s && ie_reg
        && ack_reg == ACK_NONE;

    // cycle launch priority: acknowledge, boot fetch, software
    assign cyc_done = (phase_reg == PH_T4);
    // second ack follows the first straight from its T4
    assign start_ack = (ack_reg == ACK_FIRST
            && (phase_reg == PH_IDLE || cyc_done))
        || (ack_reg == ACK_SECOND && phase_reg == PH_IDLE);
    assign start_boot = !start_ack && boot_pend_reg;
    assign start_sw = !start_ack && !boot_pend_reg && sw_pend_reg
        && ack_reg == ACK_NONE;
    assign start = !rst_pin_s && !hold_reg
        && (phase_reg == PH_IDLE || cyc_done)
        && (start_ack || start_boot || start_sw);
    // direct form keeps only the low port byte
    assign sw_io_addr = sw_direct_reg ? {12'h000, sw_addr_reg[7:0]}
        : {4'h0, ioptr_reg};
    assign is_io = (code_reg == CYC_IO_READ) || (code_reg == CYC_IO_WRITE);

    // bus phase sequencing
    always_comb begin
        phase_next = phase_reg;
        case (phase_reg)
            PH_IDLE: phase_next = start ? PH_T1 : PH_IDLE;
            PH_T1: phase_next = PH_T2;
            PH_T2: phase_next = PH_T3;
            PH_T3: phase_next = ready_s ? PH_T4 : PH_TW;
            PH_TW: phase_next = ready_s ? PH_T4 : PH_TW;
            PH_T4: phase_next = start ? PH_T1 : PH_IDLE;
            default: phase_next = PH_IDLE;
        endcase
        if (rst_pin_s) begin
            phase_next = PH_IDLE;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            phase_reg <= PH_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // capture the cycle being launched
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            code_reg <= CYC_PASSIVE;
            seg_reg <= SEG_CODE;
            addr_reg <= 20'h0_0000;
        end else if (start) begin
            if (start_ack) begin
                code_reg <= CYC_INT_ACK;
                seg_reg <= SEG_CODE;
            end else if (start_boot) begin
                code_reg <= CYC_FETCH;
                seg_reg <= SEG_CODE;
                addr_reg <= BOOT_ADDR;
            end else begin
                code_reg <= sw_code_reg;
                seg_reg <= sw_seg_reg;
                if (sw_code_reg == CYC_IO_READ
                    || sw_code_reg == CYC_IO_WRITE) begin
                    addr_reg <= sw_io_addr;
                end else begin
                    addr_reg <= sw_addr_reg;
                end
            end
        end
    end

    // two acknowledge cycles, back to back
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || rst_pin_s) begin
            ack_reg <= ACK_NONE;
        end else if (take_maskable_request) begin
            ack_reg <= ACK_FIRST;
        end else if (start && start_ack && ack_reg == ACK_FIRST
                     && phase_reg != PH_IDLE
                     && code_reg == CYC_INT_ACK) begin
            ack_reg <= ACK_SECOND;
        end else if (ack_reg == ACK_FIRST && phase_reg == PH_T4
                     && code_reg == CYC_INT_ACK) begin
            ack_reg <= ACK_SECOND;
        end else if (ack_reg == ACK_SECOND && cyc_done) begin
            ack_reg <= ACK_NONE;
        end
    end

    // read data and ack vector type taken when ready closes the transfer, in a clock that takes no nmi; a taken nmi loads NMI_TYPE
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rdata_reg <= 8'h00;
            vtype_reg <= 8'h00;
        end else if (take_nmi) begin
            vtype_reg <= NMI_TYPE;
        end else if ((phase_reg == PH_T3 || phase_reg == PH_TW)
                     && ready_s) begin
            rdata_reg <= ad_s;
            if (code_reg == CYC_INT_ACK && ack_reg == ACK_SECOND) begin
                vtype_reg <= ad_s;
            end
        end
    end

    // interrupt enable flag and its saved copy
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || rst_pin_s) begin
            ie_reg <= IE_RESET;
            saved_ie_reg <= IE_RESET;
        end else if (take_nmi || take_maskable_request) begin
            saved_ie_reg <= ie_reg;
            ie_reg <= 1'b0;
        end else if (wr_en && i_paddr == OFS_CTRL) begin
            if (i_pwdata[CTRL_RESTORE_BIT]) begin
                ie_reg <= saved_ie_reg;
            end else begin
                ie_reg <= i_pwdata[CTRL_IE_BIT];
            end
        end
    end

    // counts clocks from reset release: boot delay and nmi arming
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || rst_pin_s) begin
            post_cnt_reg <= 3'h0;
            rst_prev_reg <= 1'b1;
            boot_pend_reg <= 1'b0;
        end else begin
            rst_prev_reg <= 1'b0;
            if (post_cnt_reg != RESET_SEQ_CLKS) begin
                post_cnt_reg <= post_cnt_reg + 3'h1;
            end
            if (post_cnt_reg == RESET_SEQ_CLKS - 3'h1) begin
                boot_pend_reg <= 1'b1;
            end else if (start && start_boot) begin
                boot_pend_reg <= 1'b0;
            end
        end
    end

    // nmi edge latch; a new edge during service sets it again
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || rst_pin_s) begin
            nmi_prev_reg <= 1'b1;
            nmi_pend_reg <= 1'b0;
        end else begin
            nmi_prev_reg <= nmi_s;
            if (nmi_s && !nmi_prev_reg && post_cnt_reg >= NMI_ARM_CLKS) begin
                nmi_pend_reg <= 1'b1;
            end else if (take_nmi) begin
                nmi_pend_reg <= 1'b0;
            end
        end
    end

    // hold grant only between cycles, never inside the ack pair
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            hold_reg <= 1'b0;
        end else if (!hold_s) begin
            hold_reg <= 1'b0;
        end else if (phase_reg == PH_IDLE && ack_reg == ACK_NONE
                     && !start) begin
            hold_reg <= 1'b1;
        end
    end

    // software cycle request; refused while one is pending
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            sw_pend_reg <= 1'b0;
            sw_code_reg <= CYC_PASSIVE;
            sw_seg_reg <= SEG_CODE;
            sw_direct_reg <= 1'b0;
            sw_addr_reg <= 20'h0_0000;
            ioptr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
        end else begin
            if (start && start_sw) begin
                sw_pend_reg <= 1'b0;
            end else if (wr_en && i_paddr == OFS_CYCLE && !sw_pend_reg
                         && i_pwdata[CYC_GO_BIT] && sw_ok) begin
                sw_pend_reg <= 1'b1;
                sw_code_reg <= i_pwdata[CYC_CODE_LSB +: 3];
                sw_seg_reg <= i_pwdata[CYC_SEG_LSB +: 2];
                sw_direct_reg <= i_pwdata[CYC_DIRECT_BIT];
            end
            if (wr_en && i_paddr == OFS_ADDR) begin
                sw_addr_reg <= i_pwdata[19:0];
            end
            if (wr_en && i_paddr == OFS_IOPTR) begin
                ioptr_reg <= i_pwdata[15:0];
            end
            if (wr_en && i_paddr == OFS_WDATA) begin
                wdata_reg <= i_pwdata[7:0];
            end
        end
    end

    // bus outputs registered from the next phase
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_ale <= 1'b0;
            o_cycle_type_n <= CYC_PASSIVE;
            o_low_addr_data <= 8'h00;
            o_low_addr_data_oe <= 1'b0;
            o_mid_address_lines <= 8'h00;
            o_top_address_status_lines <= 4'h0;
            o_request_acknowledge_strobe_n <= 1'b1;
        end else begin
            o_ale <= (phase_next == PH_T1);
            o_request_acknowledge_strobe_n <= !(code_reg == CYC_INT_ACK
                && (phase_next == PH_T2 || phase_next == PH_T3
                    || phase_next == PH_TW));
            if (phase_next == PH_IDLE || phase_next == PH_T4) begin
                o_cycle_type_n <= CYC_PASSIVE;
            end else if (phase_next == PH_T1 && phase_reg != PH_T1) begin
                o_cycle_type_n <= start_ack ? CYC_INT_ACK
                    : start_boot ? CYC_FETCH : sw_code_reg;
            end
            if (phase_next == PH_T1) begin
                o_low_addr_data <= start_ack ? o_low_addr_data
                    : start_boot ? BOOT_ADDR[7:0] : sw_next_addr[7:0];
                o_low_addr_data_oe <= !start_ack;
                if (!start_ack) begin
                    o_mid_address_lines <= start_boot ? BOOT_ADDR[15:8]
                        : sw_next_addr[15:8];
                    o_top_address_status_lines <= start_boot
                        ? BOOT_ADDR[19:16] : sw_next_addr[19:16];
                end
            end else if (phase_next == PH_IDLE) begin
                o_low_addr_data_oe <= 1'b0;
            end else begin
                // status bits replace the top address nibble
                o_top_address_status_lines <= {1'b0, ie_reg, seg_reg};
                o_low_addr_data <= wdata_reg;
                o_low_addr_data_oe <= (code_reg == CYC_MEM_WRITE
                    || code_reg == CYC_IO_WRITE);
            end
        end
    end

    assign sw_next_addr = (sw_code_reg == CYC_IO_READ
        || sw_code_reg == CYC_IO_WRITE) ? sw_io_addr : sw_addr_reg;

    // lock spans T2 of the first ack to T2 of the second, max mode only
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || rst_pin_s) begin
            o_lock_n <= 1'b1;
        end else if (phase_next == PH_T2 && code_reg == CYC_INT_ACK) begin
            o_lock_n <= !(ack_reg == ACK_FIRST && !strap_s);
        end
    end
    assign o_hold_ack = hold_reg;

    // apb read mux; unmapped addresses answer with an error
    always_comb begin
        o_prdata = 32'h0000_0000;
        o_pslverr = 1'b0;
        if (i_paddr == OFS_CTRL) begin
            o_prdata[CTRL_IE_BIT] = ie_reg;
        end else if (i_paddr == OFS_CYCLE) begin
            o_prdata = {sw_pend_reg, 22'h00_0000, sw_direct_reg, 2'h0,
                sw_seg_reg, 1'b0, sw_code_reg};
        end else if (i_paddr == OFS_ADDR) begin
            o_prdata = {12'h000, sw_addr_reg};
        end else if (i_paddr == OFS_IOPTR) begin
            o_prdata = {16'h0000, ioptr_reg};
        end else if (i_paddr == OFS_WDATA) begin
            o_prdata = {24'h00_0000, wdata_reg};
        end else if (i_paddr == OFS_STATUS) begin
            o_prdata = {!strap_s, rst_pin_s, saved_ie_reg,
                ack_reg != ACK_NONE, nmi_pend_reg,
                phase_reg != PH_IDLE || sw_pend_reg,
                vtype_reg, 2'h0, vtype_reg, rdata_reg};
        end else if (i_paddr == OFS_PHASE) begin
            o_prdata = {26'h000_0000, phase_reg};
        end else begin
            o_pslverr = i_psel && i_penable;
        end
    end

    // checks on the bus sequencing and interrupt handling
    a_phase_order: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (phase_reg == PH_T1 && !rst_pin_s) |=> phase_reg == PH_T2 ##1
        (phase_reg == PH_T3 || rst_pin_s))
        else $error("bus phases out of order");
    a_wait_insert: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (phase_reg == PH_T3 && !ready_s && !rst_pin_s) |=>
        phase_reg == PH_TW)
        else $error("no wait phase while not ready");
    a_strobe_t1: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_ale == (phase_reg == PH_T1))
        else $error("address strobe outside address phase");
    a_status_bits: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (phase_reg == PH_T2 || phase_reg == PH_T3) |->
        o_top_address_status_lines == {1'b0, ie_reg, seg_reg})
        else $error("upper status bits wrong");
    a_io_top_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (phase_reg == PH_T1 && is_io) |->
        o_top_address_status_lines == 4'h0)
        else $error("io cycle drives top address lines");
    a_reset_dormant: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_n)
        rst_pin_s |=> phase_reg == PH_IDLE && o_ale == 1'b0)
        else $error("activity during reset");
    a_boot_fetch: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ($fell(rst_pin_s) && !hold_s) ##1 (!rst_pin_s && !hold_s)[*8] |->
        ##[0:2] (phase_reg == PH_T1 && addr_reg == BOOT_ADDR))
        else $error("no boot fetch after reset");
    a_ie_cleared: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (take_nmi || take_maskable_request) && !rst_pin_s |=> !ie_reg
        && saved_ie_reg == $past(ie_reg))
        else $error("interrupt enable not cleared");
    a_nmi_type: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        take_nmi && !rst_pin_s |=> vtype_reg == NMI_TYPE
        && ack_reg == ACK_NONE)
        else $error("nmi vector type wrong");
    a_nmi_masked: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (post_cnt_reg < NMI_ARM_CLKS && !nmi_pend_reg) |=>
        !nmi_pend_reg)
        else $error("nmi accepted too soon after reset");
    a_ack_pair: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (phase_reg == PH_T4 && ack_reg == ACK_FIRST && !rst_pin_s) |=>
        ack_reg == ACK_SECOND)
        else $error("second acknowledge missing");
    c_wait_seen: cover property (@(posedge i_clk_sys) phase_reg == PH_TW);
    c_ack_done: cover property (@(posedge i_clk_sys)
        ack_reg == ACK_SECOND && cyc_done);
    c_nmi_taken: cover property (@(posedge i_clk_sys) take_nmi);
    c_io_write: cover property (@(posedge i_clk_sys)
        phase_reg == PH_T4 && code_reg == CYC_IO_WRITE);
endmodule : cpu_bus_ctrl

// [cpu_bus_pkg.sv]
package cpu_bus_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CYCLE = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_IOPTR = 8'h0C;
    localparam logic [7:0] OFS_WDATA = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_PHASE = 8'h18;
    // control register bits
    localparam int CTRL_IE_BIT = 0;
    localparam int CTRL_RESTORE_BIT = 1;
    localparam int CTRL_BOUNDARY_BIT = 2;
    // cycle register fields
    localparam int CYC_CODE_LSB = 0;
    localparam int CYC_SEG_LSB = 4;
    localparam int CYC_DIRECT_BIT = 8;
    localparam int CYC_GO_BIT = 31;
    // status register fields
    localparam int ST_VTYPE_LSB = 8;
    localparam int ST_VADDR_LSB = 16;
    localparam int ST_BUSY_BIT = 26;
    localparam int ST_NMI_BIT = 27;
    localparam int ST_INT_BIT = 28;
    localparam int ST_SAVED_IE_BIT = 29;
    localparam int ST_RESET_BIT = 30;
    localparam int ST_MAXMODE_BIT = 31;
    // cycle type codes on the active-low status lines
    localparam logic [2:0] CYC_INT_ACK = 3'h0;
    localparam logic [2:0] CYC_IO_READ = 3'h1;
    localparam logic [2:0] CYC_IO_WRITE = 3'h2;
    localparam logic [2:0] CYC_HALT = 3'h3;
    localparam logic [2:0] CYC_FETCH = 3'h4;
    localparam logic [2:0] CYC_MEM_READ = 3'h5;
    localparam logic [2:0] CYC_MEM_WRITE = 3'h6;
    localparam logic [2:0] CYC_PASSIVE = 3'h7;
    // segment codes
    localparam logic [1:0] SEG_EXTRA = 2'h0;
    localparam logic [1:0] SEG_STACK = 2'h1;
    localparam logic [1:0] SEG_CODE = 2'h2;
    localparam logic [1:0] SEG_DATA = 2'h3;
    // reset values and fixed addresses
    localparam logic IE_RESET = 1'b0;
    localparam logic [19:0] BOOT_ADDR = 20'hF_FFF0;
    localparam logic [7:0] NMI_TYPE = 8'h02;
    // timing counts in processor clocks
    localparam logic [2:0] RESET_SEQ_CLKS = 3'h7;
    localparam logic [2:0] NMI_ARM_CLKS = 3'h2;
    // bus phases, one-hot
    typedef enum logic [5:0] {
        PH_IDLE = 6'b00_0001,
        PH_T1 = 6'b00_0010,
        PH_T2 = 6'b00_0100,
        PH_T3 = 6'b00_1000,
        PH_TW = 6'b01_0000,
        PH_T4 = 6'b10_0000
    } phase_type;
    // acknowledge sequencing, one-hot
    typedef enum logic [2:0] {
        ACK_NONE = 3'b001,
        ACK_FIRST = 3'b010,
        ACK_SECOND = 3'b100
    } ack_type;
endpackage : cpu_bus_pkg

// [pin_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser, one chain per bit
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            // first flop feeds only the second
            always_ff @(posedge i_clk_sys) begin
                if (!i_rst_n) begin
                    meta_reg[b] <= 1'b0;
                    o_sync[b] <= 1'b0;
                end else begin
                    meta_reg[b] <= i_async[b];
                    o_sync[b] <= meta_reg[b];
                end
            end
        end
    endgenerate
endmodule : pin_sync

// [bus_partner.sv]
`timescale 1ns/1ps
// addressed party: ready some clocks after the strobe, byte on the bus
module bus_partner (
    // clock
    input wire logic i_clk,
    // bus seen from the far side
    input wire logic i_ale,
    input wire logic [2:0] i_type_n,
    // behaviour
    input wire logic [3:0] i_waits,
    input wire logic [7:0] i_byte,
    // answer
    output logic o_ready,
    output logic [7:0] o_data
);
    logic [3:0] cnt_reg = 4'h0;
    // not ready by default, so slow answers really stretch the cycle
    always @(posedge i_clk) begin
        cnt_reg <= i_ale ? 4'h0 : cnt_reg + 4'(cnt_reg != 4'hF);
        o_ready <= i_type_n != 3'h7 && !i_ale && cnt_reg >= i_waits;
        // released bus toggles, a stale byte never looks valid
        o_data <= i_type_n != 3'h7 ? i_byte : ~o_data;
    end
    initial o_data = 8'h00;
endmodule : bus_partner

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
    import cpu_bus_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, rdy, ale, serr;
    logic crst = 1, nmi = 0, mreq = 0, prdy;
    logic [7:0] pa = 0, pb = 0, lad, mid, lo, b;
    logic [31:0] pwd = 0, prd, last_rd;
    logic [3:0] wt = 0, top;
    logic [2:0] ty, code;
    logic [32:0] mq[$], eq[$];
    logic [19:0] ad, ex;
    int errors = 0, samples_checked = 0;
    always #2 clk = ~clk;
    cpu_bus_ctrl i_cpu_bus_ctrl (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
        .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(serr),
        .i_cpu_reset(crst), .i_ready(rdy), .i_nmi(nmi),
        .i_maskable_request(mreq), .i_bus_mode_strap(1'b0),
        .i_hold_request(1'b0), .i_low_addr_data(lad),
        .o_low_addr_data(lo), .o_low_addr_data_oe(),
        .o_mid_address_lines(mid), .o_top_address_status_lines(top),
        .o_ale(ale), .o_cycle_type_n(ty),
        .o_request_acknowledge_strobe_n(), .o_lock_n(), .o_hold_ack());
    bus_partner i_bus_partner (.i_clk(clk), .i_ale(ale), .i_type_n(ty),
        .i_waits(wt), .i_byte(pb), .o_ready(rdy), .o_data(lad));
    task automatic close_out;
        if (errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [32:0] s, e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // one apb transfer, held until pready at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input int d);
        int n;
        {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 40);
        if (n == 40) chk("pready", 1, 0);
        if (n == 40) close_out();
        {psel, pen} <= 2'b00;
        @(posedge clk);
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [32:0] m, e);
        mq.push_back(m);
        eq.push_back(e);
        xfer(1'b0, a, 0);
    endtask : rd
    // poll busy; a hang counts as a mismatch
    task automatic idle_wait;
        int n;
        for (n = 0; n < 60; n++) begin
            rd(OFS_STATUS, 0, 0);
            if (last_rd[ST_BUSY_BIT] === 1'b0) break;
        end
        if (n == 60) chk("busy", 1, 0);
        if (n == 60) close_out();
    endtask : idle_wait
    task automatic ale_wait;
        int n;
        for (n = 0; n < 300 && ale !== 1'b1; n++) @(negedge clk);
        if (n == 300) chk("ale", 1, 0);
        if (n == 300) close_out();
    endtask : ale_wait
    // read data compared where it stands, before the taking edge
    always @(negedge clk) begin
        if (psel && pen && !pwr && prdy) begin
            last_rd = prd;
            chk("read", {serr, prd} & mq.pop_front(), eq.pop_front());
        end
    end
    initial begin
        void'($urandom(85903));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL, 1, {32'h0, IE_RESET});
        repeat (5) @(posedge clk);
        crst <= 1'b0;
        ale_wait();
        chk("boot", {top, mid, lo, ty}, {BOOT_ADDR, CYC_FETCH});
        @(posedge clk);
        idle_wait();
        for (int i = 0; i < 5; i++) begin
            code = i[2] ? 3'(i + 2) : 3'(i + 1 + (i > 1));
            ad = 20'($urandom);
            b = 8'($urandom);
            {pb, wt} <= {b, 4'(2 + i)};
            ex = code[2] ? ad : {4'h0, ad[15:8] & {8{i != 0}}, ad[7:0]};
            xfer(1'b1, OFS_ADDR, ad);
            xfer(1'b1, OFS_IOPTR, ad[15:0]);
            xfer(1'b1, OFS_WDATA, b);
            xfer(1'b1, OFS_CYCLE, {1'b1, 22'h0, i == 0, 2'h0, 2'(i), 1'b0,
                code});
            ale_wait();
            chk("addr", {top, mid, lo, ty}, {ex, code});
            @(negedge clk);
            chk("stat", {ale, top, ty}, {3'h0, 2'(i), code});
            @(posedge clk);
            idle_wait();
            if (code[0]) rd(OFS_STATUS, 'hFF, b);
        end
        b = 8'($urandom);
        {pb, mreq} <= {b, 1'b1};
        xfer(1'b1, OFS_CTRL, 1);
        xfer(1'b1, OFS_CTRL, 5);
        idle_wait();
        rd(OFS_STATUS, 'h3FF_FF00, {7'h0, b, 2'h0, b, 8'h0});
        rd(OFS_CTRL, 1, 0);
        xfer(1'b1, OFS_CTRL, 2);
        rd(OFS_CTRL, 1, 1);
        nmi <= 1'b1;
        repeat (4) @(posedge clk);
        nmi <= 1'b0;
        xfer(1'b1, OFS_CTRL, 5);
        idle_wait();
        rd(OFS_STATUS, 'hFF00, {NMI_TYPE, 8'h0});
        rd(8'h1C, 33'h1_0000_0000, 33'h1_0000_0000);
        close_out();
    end
endmodule : testbench
